// *** src/pwm_ctrl_pkg.sv ***
// Shared constants, types and register map of the PWM cycle controller.
// Assumes a single 200 MHz system clock and an APB master with 32-bit data.
package pwm_ctrl_pkg;

    // ==========================================
    // Clock and widths
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned PER_W = 16;
    localparam logic [15:0] PER_MAX = 16'hFFFF;
    localparam int unsigned FLAG_W = 7;
    localparam int unsigned SYNC_W = 10;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ==========================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] SKIP_OFS = 8'h08;
    localparam logic [7:0] TRIP_OFS = 8'h0C;
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_SKIP_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam int unsigned STAT_STATE_POS = 0;
    localparam int unsigned STAT_MODE_POS = 2;
    localparam int unsigned STAT_SKIP_POS = 4;
    localparam int unsigned STAT_SR_POS = 5;
    localparam int unsigned STAT_SHORT_POS = 6;
    localparam int unsigned STAT_VALID_POS = 7;

    // ==========================================
    // Types
    typedef enum logic [1:0] {DUTY_100, DUTY_75, DUTY_50} duty_mode_type;
    typedef enum logic [1:0] {HIC_RUN, HIC_PULLUP, HIC_SINK} hic_state_type;

    typedef struct packed {
        logic comp_low;
        logic pwm_trip;
        logic ilim_trip;
        logic hic_upper;
        logic hic_top;
        logic hic_bottom;
        logic ss_high;
    } analog_flags_type;

    typedef struct packed {
        logic primary_out_first;
        logic primary_out_second;
        logic rectifier_out_first;
        logic rectifier_out_second;
    } gate_type;

    typedef struct packed {
        logic charge_en;
        logic pullup_en;
        logic sink_en;
        logic ss_discharge;
    } hiccup_drive_type;

endpackage

// *** src/pwm_skip_dutylimit_hiccup_ctrl.sv ***
// Switching-cycle control of a dual-output current-mode PWM controller.
// Assumes comparator flags and straps arrive asynchronously; APB on sys_clk.
//
// Behaviour
// (R1) Pulse skipping holds both primary outputs off for whole cycles.
// (R2) After soft-start, active rectifier outputs stay on through skipped cycles.
// (R3) Skipping during soft-start leaves rectifier outputs off.
// (R4) Skip only when error level is low and previous duty was under 25%.
// (R5) At 50% limit, skip both outputs equally to keep volt-second balance.
// (R6) Three-state strap picks 100%, 75% or 50% maximum duty.
// (R7) Second primary and rectifier outputs only work at 50% limit.
// (R8) External clock source should have 50% duty; 75% limit may vary.
// (R9) Pulse starts on clock event, ends on peak current comparator.
// (R10) Over current limit, each cycle turns on then off at threshold.
// (R11) Current limit trip charges hiccup node until cycle end.
// (R12) Delay phase keeps limiting until hiccup node reaches 0.6 V.
// (R13) At 0.6 V the soft-start node discharges and switching stops.
// (R14) After stopping, hiccup node is pulled up to 1 V.
// (R15) At 1 V a restart sink discharges node; no switching until 0.3 V.
// (R16) At 0.3 V a new soft-start begins.
// (R17) Rectifier outputs stay off until soft-start exceeds 1 V.
// (R18) External clock runs at twice switching rate; device switches at half.
// (R19) Comparator flags are synchronised to sys_clk before use.
// (R20) On-time is measured against period for previous-cycle duty status.
//
// Local design decisions: register access over APB and the address map.
module pwm_skip_dutylimit_hiccup_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog side
    input wire pwm_ctrl_pkg::analog_flags_type flags_async,
    input wire logic clk_event_async,
    input wire logic strap_to_supply,
    input wire logic strap_to_ground,
    // Gate and hiccup drives
    output pwm_ctrl_pkg::gate_type gates,
    output pwm_ctrl_pkg::hiccup_drive_type hiccup_drive
);

    // ==========================================
    // Input synchronisers
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    pwm_ctrl_pkg::analog_flags_type flg;
    logic ev_s;
    logic strap_hi_s;
    logic strap_lo_s;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end else begin
            sync1_q <= {strap_to_supply, strap_to_ground, clk_event_async, flags_async}; // R19
            sync2_q <= sync1_q;
        end
    end

    assign flg = sync2_q[6:0];
    assign ev_s = sync2_q[7];
    assign strap_lo_s = sync2_q[8];
    assign strap_hi_s = sync2_q[9];

    // ==========================================
    // Strap capture after reset release
    logic [1:0] strap_wait_q;
    logic strap_valid_q;
    pwm_ctrl_pkg::duty_mode_type mode_q;
    logic mode50;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_wait_q <= 2'h0;
            strap_valid_q <= 1'b0;
            mode_q <= pwm_ctrl_pkg::DUTY_75;
        end else if (!strap_valid_q) begin
            if (strap_wait_q == pwm_ctrl_pkg::STRAP_WAIT) begin
                strap_valid_q <= 1'b1;
                // Both ties at once is illegal; treated as open
                if (strap_hi_s && !strap_lo_s) begin
                    mode_q <= pwm_ctrl_pkg::DUTY_100; // R6
                end else if (strap_lo_s && !strap_hi_s) begin
                    mode_q <= pwm_ctrl_pkg::DUTY_50; // R6
                end else begin
                    mode_q <= pwm_ctrl_pkg::DUTY_75; // R6
                end
            end else begin
                strap_wait_q <= strap_wait_q + 2'h1;
            end
        end
    end

    assign mode50 = (mode_q == pwm_ctrl_pkg::DUTY_50);

    // ==========================================
    // Registers
    logic [1:0] ctrl_q;
    logic [31:0] skip_cnt_q;
    logic [31:0] trip_cnt_q;
    logic wr_en;
    logic cnt_clr;

    assign wr_en = psel && penable && pready && pwrite;
    assign cnt_clr = wr_en && (paddr == pwm_ctrl_pkg::SKIP_OFS || paddr == pwm_ctrl_pkg::TRIP_OFS);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= pwm_ctrl_pkg::CTRL_RST;
        end else if (wr_en && paddr == pwm_ctrl_pkg::CTRL_OFS) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // ==========================================
    // Switching cycle timing; one cycle per two clock events
    logic ev_prev_q;
    logic half_q;
    logic cyc_start;
    logic [15:0] period_cnt_q;
    logic [15:0] last_period_q;
    logic [15:0] on_cnt_q;
    logic [15:0] on_limit;
    logic prev_short_q;

    assign cyc_start = ev_s && !ev_prev_q && half_q; // R18

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_prev_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            ev_prev_q <= ev_s;
            if (ev_s && !ev_prev_q) begin
                half_q <= !half_q;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            period_cnt_q <= 16'h0000;
            last_period_q <= 16'h0000;
            prev_short_q <= 1'b0;
        end else if (cyc_start) begin
            period_cnt_q <= 16'h0000;
            last_period_q <= period_cnt_q;
            // Short when four times on-time stays below the period
            prev_short_q <= ({2'b00, on_cnt_q} << 2) < {2'b00, period_cnt_q}; // R20
        end else if (period_cnt_q != pwm_ctrl_pkg::PER_MAX) begin
            period_cnt_q <= period_cnt_q + 16'h0001;
        end
    end

    always_comb begin
        case (mode_q)
            pwm_ctrl_pkg::DUTY_100: on_limit = last_period_q;
            pwm_ctrl_pkg::DUTY_50: on_limit = last_period_q >> 1;
            default: on_limit = 16'((({2'b00, last_period_q} << 1) + {2'b00, last_period_q}) >> 2);
        endcase
    end

    // ==========================================
    // Hiccup sequencer
    pwm_ctrl_pkg::hic_state_type hic_q;
    logic run_ok;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hic_q <= pwm_ctrl_pkg::HIC_RUN;
        end else begin
            case (hic_q)
                pwm_ctrl_pkg::HIC_RUN: begin
                    if (flg.hic_upper) begin
                        hic_q <= pwm_ctrl_pkg::HIC_PULLUP; // R12 R13
                    end
                end
                pwm_ctrl_pkg::HIC_PULLUP: begin
                    if (flg.hic_top) begin
                        hic_q <= pwm_ctrl_pkg::HIC_SINK; // R15
                    end
                end
                pwm_ctrl_pkg::HIC_SINK: begin
                    if (flg.hic_bottom) begin
                        hic_q <= pwm_ctrl_pkg::HIC_RUN; // R16
                    end
                end
                default: hic_q <= pwm_ctrl_pkg::HIC_RUN;
            endcase
        end
    end

    assign run_ok = (hic_q == pwm_ctrl_pkg::HIC_RUN) && ctrl_q[pwm_ctrl_pkg::CTRL_RUN_BIT]
        && strap_valid_q;

    // ==========================================
    // Pulse generation and skipping
    logic phase_b_q;
    logic next_b;
    logic skip_q;
    logic skip_d;
    logic pulse_q;
    logic sr_active_q;

    assign next_b = mode50 && !phase_b_q;

    always_comb begin
        skip_d = skip_q;
        if (cyc_start && !next_b) begin
            skip_d = ctrl_q[pwm_ctrl_pkg::CTRL_SKIP_BIT] && flg.comp_low && prev_short_q; // R4
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_b_q <= 1'b0;
            skip_q <= 1'b0;
        end else if (cyc_start) begin
            phase_b_q <= next_b;
            // Decision taken on the first output holds for the pair
            skip_q <= skip_d; // R5
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_q <= 1'b0;
            on_cnt_q <= 16'h0000;
        end else if (cyc_start) begin
            pulse_q <= run_ok && !skip_d; // R1 R9 R10
            on_cnt_q <= 16'h0000;
        end else if (!run_ok || flg.pwm_trip || flg.ilim_trip
                     || (mode_q != pwm_ctrl_pkg::DUTY_100 && on_cnt_q >= on_limit)) begin
            pulse_q <= 1'b0; // R9 R10
        end else if (pulse_q) begin
            on_cnt_q <= on_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_active_q <= 1'b0;
        end else if (!run_ok) begin
            sr_active_q <= 1'b0;
        end else if (flg.ss_high) begin
            sr_active_q <= 1'b1; // R17
        end
    end

    // ==========================================
    // Outputs
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gates <= '0;
        end else begin
            gates.primary_out_first <= pulse_q && !phase_b_q;
            gates.primary_out_second <= pulse_q && phase_b_q && mode50; // R7
            gates.rectifier_out_first <= sr_active_q && !(pulse_q && !phase_b_q); // R2 R3
            gates.rectifier_out_second <= sr_active_q && mode50 && !(pulse_q && phase_b_q); // R7
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hiccup_drive <= '0;
        end else begin
            if (cyc_start || hic_q != pwm_ctrl_pkg::HIC_RUN) begin
                hiccup_drive.charge_en <= 1'b0; // R11
            end else if (flg.ilim_trip) begin
                hiccup_drive.charge_en <= 1'b1; // R11
            end
            hiccup_drive.pullup_en <= (hic_q == pwm_ctrl_pkg::HIC_PULLUP); // R14
            hiccup_drive.sink_en <= (hic_q == pwm_ctrl_pkg::HIC_SINK); // R15
            hiccup_drive.ss_discharge <= !run_ok; // R13
        end
    end

    // ==========================================
    // Counters and APB answer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            skip_cnt_q <= 32'h00000000;
            trip_cnt_q <= 32'h00000000;
        end else begin
            // Counting wins over a clear in the same cycle
            if (cyc_start && skip_d && run_ok) begin
                skip_cnt_q <= skip_cnt_q + 32'h00000001;
            end else if (cnt_clr && paddr == pwm_ctrl_pkg::SKIP_OFS) begin
                skip_cnt_q <= 32'h00000000;
            end
            if (flg.ilim_trip && pulse_q) begin
                trip_cnt_q <= trip_cnt_q + 32'h00000001;
            end else if (cnt_clr && paddr == pwm_ctrl_pkg::TRIP_OFS) begin
                trip_cnt_q <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == pwm_ctrl_pkg::CTRL_OFS) begin
                    prdata <= {30'h0, ctrl_q};
                end else if (paddr == pwm_ctrl_pkg::STAT_OFS) begin
                    prdata[pwm_ctrl_pkg::STAT_STATE_POS +: 2] <= hic_q;
                    prdata[pwm_ctrl_pkg::STAT_MODE_POS +: 2] <= mode_q;
                    prdata[pwm_ctrl_pkg::STAT_SKIP_POS] <= skip_q;
                    prdata[pwm_ctrl_pkg::STAT_SR_POS] <= sr_active_q;
                    prdata[pwm_ctrl_pkg::STAT_SHORT_POS] <= prev_short_q;
                    prdata[pwm_ctrl_pkg::STAT_VALID_POS] <= strap_valid_q;
                end else if (paddr == pwm_ctrl_pkg::SKIP_OFS) begin
                    prdata <= skip_cnt_q;
                end else if (paddr == pwm_ctrl_pkg::TRIP_OFS) begin
                    prdata <= trip_cnt_q;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    skip_blocks_pulse_a: assert property (cyc_start && skip_d |=> !pulse_q) // R1
        else $error("pulse issued in skipped cycle");
    sr_hold_skip_a: assert property (skip_q && sr_active_q && !pulse_q |=> gates.rectifier_out_first) // R2
        else $error("rectifier dropped in skipped cycle");
    sr_off_ss_a: assert property (!sr_active_q |=> !gates.rectifier_out_first && !gates.rectifier_out_second) // R3
        else $error("rectifier on before soft-start end");
    skip_cause_a: assert property (cyc_start && !next_b && skip_d |-> flg.comp_low && prev_short_q) // R4
        else $error("skip without both conditions");
    skip_pair_a: assert property (cyc_start && next_b |-> skip_d == skip_q) // R5
        else $error("second output skip differs from first");
    second_gate_a: assert property (!mode50 |=> !gates.primary_out_second && !gates.rectifier_out_second) // R7
        else $error("second outputs active outside 50 percent");
    peak_off_a: assert property (pulse_q && !cyc_start && (flg.pwm_trip || flg.ilim_trip) |=> !pulse_q ##1 !gates.primary_out_first) // R9
        else $error("pulse not ended by current comparator");
    charge_a: assert property (hic_q == pwm_ctrl_pkg::HIC_RUN && flg.ilim_trip && !cyc_start |=> hiccup_drive.charge_en) // R11
        else $error("hiccup charge not enabled on trip");
    stop_a: assert property (hic_q == pwm_ctrl_pkg::HIC_RUN && flg.hic_upper |=> ##1 !pulse_q && hiccup_drive.ss_discharge && hiccup_drive.pullup_en) // R13
        else $error("switching not stopped at upper level");
    restart_a: assert property (hic_q == pwm_ctrl_pkg::HIC_SINK && !flg.hic_bottom |=> hic_q == pwm_ctrl_pkg::HIC_SINK ##1 hiccup_drive.sink_en) // R15
        else $error("restart left before lower level");
    resume_a: assert property (hic_q == pwm_ctrl_pkg::HIC_SINK && flg.hic_bottom |=> hic_q == pwm_ctrl_pkg::HIC_RUN) // R16
        else $error("no soft-start after lower level");

    skip_seen_c: cover property (cyc_start && skip_d && sr_active_q);
    hiccup_loop_c: cover property (hic_q == pwm_ctrl_pkg::HIC_SINK ##1 hic_q == pwm_ctrl_pkg::HIC_RUN);
    limit_c: cover property (pulse_q && flg.ilim_trip ##1 hiccup_drive.charge_en);
    alt_c: cover property (mode50 && gates.primary_out_second);

endmodule // pwm_skip_dutylimit_hiccup_ctrl

// *** test/power_stage_model.sv ***
// Far-side model: gate drivers, power stage current, hiccup and soft-start caps.
// Assumes registered gate and hiccup drives on sys_clk; voltages are scaled counts.
module power_stage_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // From the controller
    input wire pwm_ctrl_pkg::gate_type gates,
    input wire pwm_ctrl_pkg::hiccup_drive_type hiccup_drive,
    // Bench knobs, 8'hFF disables a trip
    input wire logic comp_low_in,
    input wire logic [7:0] trip_lvl,
    input wire logic [7:0] ilim_lvl,
    // Comparator flags
    output pwm_ctrl_pkg::analog_flags_type flags
);
    timeunit 1ns;
    timeprecision 100ps;
    int cur_q;
    int cap_q;
    int ss_q;
    logic on;
    assign on = gates.primary_out_first | gates.primary_out_second;
    // ==========================================
    // Current ramps only while a primary switch conducts
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_q <= 0;
            cap_q <= 0;
            ss_q <= 0;
        end else begin
            cur_q <= on ? cur_q + 1 : 0;
            if (hiccup_drive.charge_en)
                cap_q <= cap_q + 20;
            else if (hiccup_drive.pullup_en)
                cap_q <= (cap_q >= 950) ? 1000 : cap_q + 50;
            else if (hiccup_drive.sink_en)
                cap_q <= (cap_q < 5) ? 0 : cap_q - 5;
            ss_q <= hiccup_drive.ss_discharge ? 0 : ((ss_q < 255) ? ss_q + 1 : ss_q);
        end
    end
    // Thresholds: 600 upper, 1000 top, 300 bottom, soft-start high above 120
    assign flags = {comp_low_in, on && trip_lvl != 8'hFF && cur_q >= trip_lvl,
                    on && ilim_lvl != 8'hFF && cur_q >= ilim_lvl,
                    cap_q >= 600, cap_q >= 1000, cap_q <= 300, ss_q > 120};
endmodule // power_stage_model

// *** test/testbench.sv ***
// Self-checking bench: APB master, clock event source, stage model.
// Assumes an APB slave that answers in bounded time and two-flop synced comparator flags.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [31:0] mask; logic [31:0] data; logic err;} note_type;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, trip_lvl, ilim_lvl;
    logic [7:0] ev_cnt = 8'h00;
    logic [31:0] pwdata, prdata, rd;
    logic clk_event_async, strap_to_supply, strap_to_ground, comp_low_in;
    logic prev_a, prev_b, prev_srb;
    pwm_ctrl_pkg::analog_flags_type flags;
    pwm_ctrl_pkg::gate_type gates;
    pwm_ctrl_pkg::hiccup_drive_type hiccup_drive;
    int failures, checked, seed, rise_a, rise_b, rise_srb, run_len, max_run, stop_on;
    int m, k, a0, b0, s0, lim;
    note_type notes[$];
    note_type nt;

    pwm_skip_dutylimit_hiccup_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags_async(flags),
        .clk_event_async(clk_event_async), .strap_to_supply(strap_to_supply),
        .strap_to_ground(strap_to_ground), .gates(gates), .hiccup_drive(hiccup_drive));
    power_stage_model stage (.sys_clk(sys_clk), .rst_b(rst_b), .gates(gates),
        .hiccup_drive(hiccup_drive), .comp_low_in(comp_low_in), .trip_lvl(trip_lvl),
        .ilim_lvl(ilim_lvl), .flags(flags));

    // ==========================================
    // Clock, event source at twice switching rate, even duty
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        ev_cnt <= ev_cnt + 8'h01;
        clk_event_async <= ev_cnt[4];
    end

    // ==========================================
    // Checking
    task automatic wrap_up();
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic c, input logic e);
        cmp({31'h0, c}, {31'h0, e});
    endtask
    always @(posedge sys_clk) begin
        if (psel && penable && pready) begin
            if (notes.size() == 0) begin
                chk(1'b0, 1'b1);
            end else begin
                nt = notes.pop_front();
                cmp(prdata & nt.mask, nt.data);
                chk(pslverr, nt.err);
            end
        end
        if (gates.primary_out_first && !prev_a) rise_a++;
        if (gates.primary_out_second && !prev_b) rise_b++;
        if (gates.rectifier_out_second && !prev_srb) rise_srb++;
        if ((hiccup_drive.pullup_en | hiccup_drive.sink_en) && (prev_a | prev_b)) stop_on++;
        run_len = gates.primary_out_first ? run_len + 1 : 0;
        if (run_len > max_run) max_run = run_len;
        prev_a = gates.primary_out_first;
        prev_b = gates.primary_out_second;
        prev_srb = gates.rectifier_out_second;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end

    // ==========================================
    // Drivers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] msk, input logic [31:0] e, input logic err);
        int n;
        @(posedge sys_clk);
        notes.push_back('{msk, e, err});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            failures++;
            wrap_up();
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return hiccup_drive.charge_en;
            1: return hiccup_drive.pullup_en;
            2: return hiccup_drive.sink_en;
            default: return gates.rectifier_out_first;
        endcase
    endfunction
    task automatic wait_sig(input int s, input logic lvl);
        int n;
        for (n = 0; n < 5000; n++) begin
            @(posedge sys_clk);
            if (sig(s) === lvl) break;
        end
        if (n == 5000) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic reset_dut(input logic sup, input logic gnd);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        strap_to_supply <= sup;
        strap_to_ground <= gnd;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask

    // ==========================================
    // Scenarios
    initial begin
        seed = 32'h5acb5531;
        {rst_b, psel, penable, pwrite, comp_low_in} = 5'h00;
        {strap_to_supply, strap_to_ground, paddr, pwdata} = 42'h0;
        {trip_lvl, ilim_lvl} = 16'hFFFF;
        {failures, checked, rise_a, rise_b, rise_srb, run_len, max_run, stop_on} = '0;
        {prev_a, prev_b, prev_srb} = 3'h0;
        for (m = 0; m < 3; m++) begin
            reset_dut(m == 0, m == 2);
            apb(1'b0, pwm_ctrl_pkg::CTRL_OFS, 32'h0, 32'hFFFFFFFF, 32'h3, 1'b0);
            apb(1'b0, pwm_ctrl_pkg::STAT_OFS, 32'h0, 32'h8C, 32'h80 | (m << 2), 1'b0);
            trip_lvl <= 8'd20;
            ilim_lvl <= 8'hFF;
            wait_sig(3, 1'b1);
            b0 = rise_b;
            s0 = rise_srb;
            repeat (600) @(posedge sys_clk);
            chk(rise_b != b0, m == 2);
            chk(rise_srb != s0, m == 2);
            trip_lvl <= 8'hFF;
            repeat (100) @(posedge sys_clk);
            max_run = 0;
            repeat (600) @(posedge sys_clk);
            lim = (m == 1) ? 48 : 32;
            if (m == 0) chk(max_run > 64, 1'b1);
            else chk(max_run >= lim - 4 && max_run <= lim + 1, 1'b1);
        end
        apb(1'b0, 8'h10, $random(seed), 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b1, 8'h14, $random(seed), 32'h0, 32'h0, 1'b1);
        // Skip only with low error level and short previous duty
        for (k = 0; k < 3; k++) begin
            // Pulse width settles first, else a stale short duty locks skipping
            trip_lvl <= (k == 2) ? 8'd20 : 8'd3;
            repeat (200) @(posedge sys_clk);
            comp_low_in <= (k != 1);
            repeat (200) @(posedge sys_clk);
            apb(1'b1, pwm_ctrl_pkg::SKIP_OFS, $random(seed), 32'h0, 32'h0, 1'b0);
            a0 = rise_a;
            b0 = rise_b;
            repeat (640) @(posedge sys_clk);
            chk((rise_a - a0) + (rise_b - b0) < 9, k == 0);
            chk((rise_a - a0) - (rise_b - b0) <= 1 && (rise_b - b0) - (rise_a - a0) <= 1,
                1'b1);
            apb(1'b0, pwm_ctrl_pkg::SKIP_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
            chk(rd != 32'h0, k == 0);
        end
        // Overcurrent: delay, stop, pull-up, restart sink, new soft-start
        // Start between first-output pulses so no long run leaks into max_run
        wait_sig(3, 1'b1);
        comp_low_in <= 1'b0;
        trip_lvl <= 8'd20;
        ilim_lvl <= 8'd8;
        apb(1'b1, pwm_ctrl_pkg::TRIP_OFS, $random(seed), 32'h0, 32'h0, 1'b0);
        max_run = 0;
        wait_sig(0, 1'b1);
        wait_sig(1, 1'b1);
        chk(hiccup_drive.ss_discharge, 1'b1);
        chk(max_run < 16, 1'b1);
        apb(1'b0, pwm_ctrl_pkg::STAT_OFS, 32'h0, 32'h3, 32'h1, 1'b0);
        ilim_lvl <= 8'hFF;
        wait_sig(2, 1'b1);
        wait_sig(2, 1'b0);
        chk(stop_on == 0, 1'b1);
        wait_sig(3, 1'b1);
        apb(1'b0, pwm_ctrl_pkg::TRIP_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        chk(rd != 32'h0, 1'b1);
        wrap_up();
    end
endmodule // testbench
